// >>> pos_ahb_slave.sv
/*
  AHB-Lite slave front end for the shaper registers: writes complete with no
  wait state, reads take one wait state. Assumes it is the only slave, so its
  hreadyout is also the bus hready seen on hready_i.
*/
`timescale 1ns/1ps

module pos_ahb_slave
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // AHB-Lite slave side
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // register side
  output logic wr_o,
  output logic [7:0] addr_o,
  output logic [31:0] wdata_o,
  input wire logic [31:0] rdata_i
);
  import pos_pkg::*;

  logic wphase;
  logic rphase;
  logic take;

  // only whole-word transfers are decoded; narrower ones are accepted and ignored
  assign take = hsel_i && htrans_i[1] && hready_i && (hsize_i == 3'h2);
  assign wr_o = wphase;
  assign wdata_o = hwdata_i;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wphase <= 1'b0;
      rphase <= 1'b0;
      addr_o <= 8'h00;
    end
    else
    begin
      wphase <= take && hwrite_i;
      rphase <= take && !hwrite_i;
      if (take)
      begin
        addr_o <= {haddr_i[7:2], 2'b00};
      end
    end
  end

  // the wait state lets a write in its data phase land before a read samples
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hreadyout_o <= 1'b1;
      hrdata_o <= 32'h0000_0000;
    end
    else if (take && !hwrite_i)
    begin
      hreadyout_o <= 1'b0;
    end
    else if (rphase)
    begin
      hreadyout_o <= 1'b1;
      hrdata_o <= rdata_i;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hresp_o <= 1'b0;
    end
    else
    begin
      hresp_o <= 1'b0;
    end
  end

  chk_read_wait_state: assert property (@(posedge mclk_i) disable iff (rst_i)
    (take && !hwrite_i) |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read did not take exactly one wait state");

endmodule

// >>> pos_db_model.sv
/*
  Behavioural model of the dead-band counter that the shaper hands off to.
  Assumes start pulses and times come from pos_shaper on the same clock.
*/
`timescale 1ns/1ps

module pos_db_model
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // start pulses and times from the shaper
  input wire logic rise_start_i,
  input wire logic fall_start_i,
  input wire logic [7:0] rise_time_i,
  input wire logic [7:0] fall_time_i,
  // completion pulse back
  output logic done_o
);
  logic [7:0] cnt;
  logic run;

  // a new start restarts the count, as a real counter would
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt <= 8'h00;
      run <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (rise_start_i || fall_start_i)
      begin
        run <= 1'b1;
        cnt <= rise_start_i ? rise_time_i : fall_time_i;
      end
      else if (run)
      begin
        if (cnt == 8'h00)
        begin
          run <= 1'b0;
          done_o <= 1'b1;
        end
        else
          cnt <= cnt - 8'h01;
      end
    end
  end
endmodule

// >>> pos_db_seq.sv
/*
  Primary/complementary edge sequencer with dead-band hand-off. Assumes the
  external dead-band counter answers a start pulse with a done pulse.
*/
`timescale 1ns/1ps

module pos_db_seq
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire logic rdb_en_i,
  input wire logic fdb_en_i,
  // events
  input wire logic rise_ev_i,
  input wire logic fall_ev_i,
  input wire logic db_done_i,
  // results
  output logic prim_o,
  output logic comp_o,
  output logic rdb_start_o,
  output logic fdb_start_o,
  output logic busy_o
);
  import pos_pkg::*;

  pos_db_state_type state;

  assign busy_o = (state != POS_DB_IDLE);

  // a falling event in the same cycle as a rising one wins: it ends the pulse
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= POS_DB_IDLE;
      prim_o <= 1'b0;
      comp_o <= 1'b0;
      rdb_start_o <= 1'b0;
      fdb_start_o <= 1'b0;
    end
    else if (!run_i)
    begin
      state <= POS_DB_IDLE;
      prim_o <= 1'b0;
      comp_o <= 1'b0;
      rdb_start_o <= 1'b0;
      fdb_start_o <= 1'b0;
    end
    else
    begin
      rdb_start_o <= 1'b0;
      fdb_start_o <= 1'b0;
      if (fall_ev_i)
      begin
        prim_o <= 1'b0; // see [R12]
        comp_o <= !fdb_en_i; // see [R21]
        fdb_start_o <= fdb_en_i;
        state <= fdb_en_i ? POS_DB_FALL : POS_DB_IDLE;
      end
      else if (rise_ev_i)
      begin
        comp_o <= 1'b0; // see [R11]
        prim_o <= !rdb_en_i; // see [R21]
        rdb_start_o <= rdb_en_i;
        state <= rdb_en_i ? POS_DB_RISE : POS_DB_IDLE;
      end
      else
      begin
        case (state)
          POS_DB_RISE:
          begin
            if (db_done_i)
            begin
              prim_o <= 1'b1; // see [R11]
              state <= POS_DB_IDLE;
            end
          end
          POS_DB_FALL:
          begin
            if (db_done_i)
            begin
              comp_o <= 1'b1; // see [R12]
              state <= POS_DB_IDLE;
            end
          end
          default:
          begin
            state <= POS_DB_IDLE;
          end
        endcase
      end
    end
  end

  chk_db_both_low: assert property (@(posedge mclk_i) disable iff (rst_i)
    busy_o |-> (!prim_o && !comp_o)) // see [R21]
    else $error("an output is active during a dead band");

endmodule

// >>> pos_defs.svh
/*
  Register offsets, field positions, reset values and mode codes of the
  PWM output mode shaper. Assumes inclusion by bare name from the package.
*/
`ifndef POS_DEFS_SVH
`define POS_DEFS_SVH

// byte offsets on the AHB-Lite register window
`define POS_OFS_CTRL 8'h00
`define POS_OFS_STEER 8'h04
`define POS_OFS_RDB 8'h08
`define POS_OFS_FDB 8'h0C
`define POS_OFS_STATUS 8'h10

// main control register fields
`define POS_CTRL_EN 7
`define POS_CTRL_LOAD 6
`define POS_CTRL_RDB_EN 5
`define POS_CTRL_FDB_EN 4
`define POS_CTRL_MODE_HI 3
`define POS_CTRL_MODE_LO 0

// mode field codes
`define POS_MODE_SINGLE 4'h0
`define POS_MODE_COMP 4'h1
`define POS_MODE_PUSHPULL 4'h2
`define POS_MODE_SIXSTEP 4'hC

// reset values
`define POS_RST_CTRL 8'h00
`define POS_RST_STEER 6'h00
`define POS_RST_DB 8'h00

`endif

// >>> pos_pkg.sv
/*
  Types of the PWM output mode shaper. Assumes pos_defs.svh is reachable on
  the include path.
*/
`include "pos_defs.svh"

package pos_pkg;

  typedef enum logic [3:0] {
    POS_SINGLE = `POS_MODE_SINGLE,
    POS_COMP = `POS_MODE_COMP,
    POS_PUSHPULL = `POS_MODE_PUSHPULL,
    POS_SIXSTEP = `POS_MODE_SIXSTEP
  } pos_mode_type;

  typedef enum logic [2:0] {
    POS_DB_IDLE = 3'b001,
    POS_DB_RISE = 3'b010,
    POS_DB_FALL = 3'b100
  } pos_db_state_type;

endpackage

// >>> pos_shaper.sv
/*
  PWM output mode shaper top: AHB-Lite registers, steering buffers, period
  parity and per-mode pin shaping for outputs A to F. Assumes the time base
  gives period, rising and falling strobes on mclk_i, one cycle each, and
  that an external dead-band counter takes the start pulses and times.
*/
`timescale 1ns/1ps

// Overview of operation
// [R1] waveforms come only from period, rise, fall strobes
// [R2] control register mode field selects the waveform
// [R3] six-step mode follows software-updated steering enables
// [R4] single-phase steers one PWM, no dead band
// [R5] all steered outputs carry identical waveform
// [R6] single-phase rise drives steered outputs active
// [R7] single-phase fall drives steered outputs inactive
// [R8] complementary makes opposite pair, optional dead band
// [R9] primary steerable to outputs A, C, E
// [R10] complementary steerable to outputs B, D, E
// [R11] rise: complementary off, dead band, primary on
// [R12] fall: primary off, dead band, complementary on
// [R13] push-pull alternates outputs on odd, even periods
// [R14] basic push-pull uses A, B only, unsteered
// [R15] odd period: rise sets A, fall clears A
// [R16] even period: rise sets B, fall clears B
// [R17] enabling write loads pending steering and timing
// [R18] software enables single-phase with documented control value
// [R19] software loads dead bands before enabling complementary
// [R20] parity starts odd after enable, toggles per period
// [R21] both outputs inactive while dead band runs

module pos_shaper
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // AHB-Lite register bus
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // event strobes from the time base
  input wire logic period_ev_i,
  input wire logic rise_ev_i,
  input wire logic fall_ev_i,
  // dead-band counter hand-off
  input wire logic db_done_i,
  output logic db_rise_start_o,
  output logic db_fall_start_o,
  output logic [7:0] rise_deadband_time_o,
  output logic [7:0] fall_deadband_time_o,
  // pins, active high
  output logic pwm_out_a_o,
  output logic pwm_out_b_o,
  output logic pwm_out_c_o,
  output logic pwm_out_d_o,
  output logic pwm_out_e_o,
  output logic pwm_out_f_o
);
  import pos_pkg::*;

  logic [7:0] main_control_reg;
  logic [5:0] steering_reg;
  logic [5:0] steer_act;
  logic [7:0] rdb_pend;
  logic [7:0] fdb_pend;
  logic level;
  logic odd_period;
  logic [5:0] pwm;
  logic [5:0] next_pwm;
  logic [31:0] rdata;
  logic wr;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic prim;
  logic comp;
  logic db_busy;
  logic enabled;
  logic load_now;
  logic seq_run;
  pos_mode_type mode;

  pos_ahb_slave u_ahb
  (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hsize_i(hsize_i),
    .hwdata_i(hwdata_i),
    .hready_i(hready_i),
    .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o),
    .hrdata_o(hrdata_o),
    .wr_o(wr),
    .addr_o(addr),
    .wdata_o(wdata),
    .rdata_i(rdata)
  );

  assign enabled = main_control_reg[`POS_CTRL_EN];
  assign mode = pos_mode_type'(main_control_reg[`POS_CTRL_MODE_HI:`POS_CTRL_MODE_LO]); // see [R2]
  assign load_now = wr && (addr == `POS_OFS_CTRL) && wdata[`POS_CTRL_EN]; // see [R17]
  assign seq_run = enabled && ((mode == POS_COMP) || (mode == POS_SIXSTEP));

  // register writes; the pending copies only reach the pins on an enabling write
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      main_control_reg <= `POS_RST_CTRL;
      steering_reg <= `POS_RST_STEER;
      rdb_pend <= `POS_RST_DB;
      fdb_pend <= `POS_RST_DB;
    end
    else if (wr)
    begin
      case (addr)
        `POS_OFS_CTRL: main_control_reg <= wdata[7:0];
        `POS_OFS_STEER: steering_reg <= wdata[5:0];
        `POS_OFS_RDB: rdb_pend <= wdata[7:0];
        `POS_OFS_FDB: fdb_pend <= wdata[7:0];
        default: main_control_reg <= main_control_reg;
      endcase
    end
  end

  // active buffers; the pending value written in the same cycle is not yet seen
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      steer_act <= `POS_RST_STEER;
      rise_deadband_time_o <= `POS_RST_DB;
      fall_deadband_time_o <= `POS_RST_DB;
    end
    else if (load_now)
    begin
      steer_act <= steering_reg; // see [R17]
      rise_deadband_time_o <= rdb_pend;
      fall_deadband_time_o <= fdb_pend;
    end
  end

  always_comb
  begin
    rdata = 32'h0000_0000;
    case (addr)
      `POS_OFS_CTRL: rdata = {24'h00_0000, main_control_reg};
      `POS_OFS_STEER: rdata = {26'h000_0000, steering_reg};
      `POS_OFS_RDB: rdata = {24'h00_0000, rdb_pend};
      `POS_OFS_FDB: rdata = {24'h00_0000, fdb_pend};
      `POS_OFS_STATUS: rdata = {14'h0000, steer_act, 4'h0, db_busy, odd_period, pwm};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // plain PWM level: rise sets, fall clears, fall wins on a tie
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      level <= 1'b0;
    end
    else if (!enabled)
    begin
      level <= 1'b0;
    end
    else if (fall_ev_i)
    begin
      level <= 1'b0; // see [R7]
    end
    else if (rise_ev_i)
    begin
      level <= 1'b1; // see [R6]
    end
  end

  // cleared while disabled, so the first period event after enable marks odd
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      odd_period <= 1'b0;
    end
    else if (!enabled)
    begin
      odd_period <= 1'b0; // see [R20]
    end
    else if (period_ev_i)
    begin
      odd_period <= !odd_period; // see [R20] [R1]
    end
  end

  pos_db_seq u_seq
  (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .run_i(seq_run),
    .rdb_en_i(main_control_reg[`POS_CTRL_RDB_EN]),
    .fdb_en_i(main_control_reg[`POS_CTRL_FDB_EN]),
    .rise_ev_i(rise_ev_i),
    .fall_ev_i(fall_ev_i),
    .db_done_i(db_done_i),
    .prim_o(prim),
    .comp_o(comp),
    .rdb_start_o(db_rise_start_o),
    .fdb_start_o(db_fall_start_o),
    .busy_o(db_busy)
  );

  // pin shaping per mode, one cycle behind the shaping state
  always_comb
  begin
    next_pwm = 6'h00;
    if (enabled)
    begin
      case (mode)
        POS_SINGLE:
        begin
          next_pwm = steer_act & {6{level}}; // see [R4] [R5]
        end
        POS_COMP:
        begin
          next_pwm[0] = steer_act[0] & prim; // see [R9] [R8]
          next_pwm[2] = steer_act[2] & prim;
          next_pwm[1] = steer_act[1] & comp; // see [R10]
          next_pwm[3] = steer_act[3] & comp;
          // E takes the primary when both sources are steered onto it
          next_pwm[4] = steer_act[4] ? prim : (steer_act[5] & comp);
        end
        POS_PUSHPULL:
        begin
          next_pwm[0] = level & odd_period; // see [R13] [R14] [R15]
          next_pwm[1] = level & !odd_period; // see [R16]
        end
        POS_SIXSTEP:
        begin
          // commutation is entirely software rewriting the steering buffers
          next_pwm = steer_act & {comp, prim, comp, prim, comp, prim}; // see [R3]
        end
        default:
        begin
          next_pwm = 6'h00;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pwm <= 6'h00;
    end
    else
    begin
      pwm <= next_pwm;
    end
  end

  assign pwm_out_a_o = pwm[0];
  assign pwm_out_b_o = pwm[1];
  assign pwm_out_c_o = pwm[2];
  assign pwm_out_d_o = pwm[3];
  assign pwm_out_e_o = pwm[4];
  assign pwm_out_f_o = pwm[5];

  chk_single_rise_active: assert property (@(posedge mclk_i) disable iff (rst_i)
    (enabled && mode == POS_SINGLE && rise_ev_i && !fall_ev_i && !wr)
    |=> ##1 (pwm == steer_act)) // see [R6]
    else $error("single-phase rise did not set steered outputs");

  chk_single_fall_inactive: assert property (@(posedge mclk_i) disable iff (rst_i)
    (enabled && mode == POS_SINGLE && fall_ev_i && !wr) |=> ##1 (pwm == 6'h00)) // see [R7]
    else $error("single-phase fall left an output active");

  chk_comp_rise_order: assert property (@(posedge mclk_i) disable iff (rst_i)
    (enabled && mode == POS_COMP && rise_ev_i && !fall_ev_i && !wr)
    |=> ##1 (!pwm[1] && !pwm[3])) // see [R11]
    else $error("complementary output still active after rise");

  chk_rise_db_start: assert property (@(posedge mclk_i) disable iff (rst_i)
    (seq_run && rise_ev_i && !fall_ev_i && main_control_reg[`POS_CTRL_RDB_EN] && !wr)
    |=> db_rise_start_o ##1 !db_rise_start_o) // see [R11]
    else $error("rising dead band not started for one cycle");

  chk_fall_db_start: assert property (@(posedge mclk_i) disable iff (rst_i)
    (seq_run && fall_ev_i && main_control_reg[`POS_CTRL_FDB_EN] && !wr)
    |=> db_fall_start_o && !prim) // see [R12]
    else $error("falling dead band not started");

  chk_pushpull_odd: assert property (@(posedge mclk_i) disable iff (rst_i)
    (enabled && mode == POS_PUSHPULL && odd_period && rise_ev_i && !fall_ev_i
     && !period_ev_i && !wr) |=> ##1 (pwm == 6'h01)) // see [R15]
    else $error("odd period rise did not drive A alone");

  chk_pushpull_even: assert property (@(posedge mclk_i) disable iff (rst_i)
    (enabled && mode == POS_PUSHPULL && !odd_period && rise_ev_i && !fall_ev_i
     && !period_ev_i && !wr) |=> ##1 (pwm == 6'h02)) // see [R16]
    else $error("even period rise did not drive B alone");

  chk_parity_toggle: assert property (@(posedge mclk_i) disable iff (rst_i)
    (enabled && period_ev_i && !wr) |=> (odd_period != $past(odd_period))) // see [R20]
    else $error("period parity did not toggle");

  chk_enable_load: assert property (@(posedge mclk_i) disable iff (rst_i)
    load_now |=> (steer_act == $past(steering_reg)
                  && rise_deadband_time_o == $past(rdb_pend))) // see [R17]
    else $error("enabling write did not load active buffers");

endmodule

// >>> pwm_output_mode_shaper_tb_top.sv
/*
  Self-checking bench of the PWM output mode shaper: AHB-Lite register tasks,
  event strobes and pin checks. Assumes pos_defs.svh on the include path.
*/
`timescale 1ns/1ps
`include "pos_defs.svh"

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, a, b); end end

module pwm_output_mode_shaper_tb_top;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic period_ev = 1'b0;
  logic rise_ev = 1'b0;
  logic fall_ev = 1'b0;
  logic db_done;
  logic rstart;
  logic fstart;
  logic [7:0] rtime;
  logic [7:0] ftime;
  logic [5:0] pins;
  logic [31:0] d;
  int n_mismatch = 0;
  int n_checks = 0;

  always #20 mclk_i = ~mclk_i;

  pos_shaper dut_u
  (
    .mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .period_ev_i(period_ev), .rise_ev_i(rise_ev), .fall_ev_i(fall_ev),
    .db_done_i(db_done), .db_rise_start_o(rstart), .db_fall_start_o(fstart),
    .rise_deadband_time_o(rtime), .fall_deadband_time_o(ftime),
    .pwm_out_a_o(pins[0]), .pwm_out_b_o(pins[1]), .pwm_out_c_o(pins[2]),
    .pwm_out_d_o(pins[3]), .pwm_out_e_o(pins[4]), .pwm_out_f_o(pins[5])
  );

  pos_db_model db_u
  (
    .mclk_i(mclk_i), .rst_i(rst_i), .rise_start_i(rstart), .fall_start_i(fstart),
    .rise_time_i(rtime), .fall_time_i(ftime), .done_o(db_done)
  );

  task automatic final_report();
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // values read after an edge are those the slave drove before it
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge mclk_i);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge mclk_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? wd : 32'h0;
    do @(posedge mclk_i); while (hready !== 1'b1);
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(a, 1'b1, v, x);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(a, 1'b0, 32'h0, x);
    `CHK(x, e)
  endtask

  // e = {period, rise, fall}; pins settle two edges after the strobe edge
  task automatic ev(input logic [2:0] e, input int n, input logic [5:0] p);
    @(posedge mclk_i);
    {period_ev, rise_ev, fall_ev} <= e;
    @(posedge mclk_i);
    {period_ev, rise_ev, fall_ev} <= 3'h0;
    repeat (n) @(posedge mclk_i);
    `CHK(pins, p)
  endtask

  initial
  begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    `CHK(pins, 6'h00)
    rdchk(`POS_OFS_CTRL, 32'h0);
    rdchk(`POS_OFS_STEER, 32'h0);
    rdchk(`POS_OFS_RDB, 32'h0);
    rdchk(`POS_OFS_FDB, 32'h0);
    wr(8'h20, 32'hFF);
    rdchk(8'h20, 32'h0);
    // single phase: disabled events ignored, then steered to A, C, D, F
    wr(`POS_OFS_STEER, 32'h2D);
    ev(3'b010, 3, 6'h00);
    wr(`POS_OFS_CTRL, 32'hC0);
    bus(`POS_OFS_STATUS, 1'b0, 32'h0, d);
    `CHK(d[17:12], 6'h2D)
    ev(3'b100, 3, 6'h00);
    ev(3'b010, 3, 6'h2D);
    ev(3'b001, 3, 6'h00);
    // pending steering stays pending until the next enabling write
    wr(`POS_OFS_STEER, 32'h3F);
    ev(3'b010, 3, 6'h2D);
    ev(3'b001, 3, 6'h00);
    wr(`POS_OFS_CTRL, 32'hC0);
    ev(3'b010, 3, 6'h3F);
    // complementary with both dead-band times set to six
    wr(`POS_OFS_CTRL, 32'h00);
    wr(`POS_OFS_RDB, 32'h06);
    wr(`POS_OFS_FDB, 32'h06);
    wr(`POS_OFS_STEER, 32'h0F);
    wr(`POS_OFS_CTRL, 32'hF1);
    rdchk(`POS_OFS_CTRL, 32'hF1);
    `CHK(rtime, 8'h06)
    `CHK(ftime, 8'h06)
    ev(3'b001, 3, 6'h00);
    repeat (20) @(posedge mclk_i);
    `CHK(pins, 6'h0A)
    ev(3'b010, 3, 6'h00);
    repeat (20) @(posedge mclk_i);
    `CHK(pins, 6'h05)
    // complementary without dead band, E carries the primary
    wr(`POS_OFS_STEER, 32'h13);
    wr(`POS_OFS_CTRL, 32'hC1);
    ev(3'b001, 3, 6'h02);
    ev(3'b010, 3, 6'h11);
    // E carries the complementary when only its second steer bit is set
    wr(`POS_OFS_STEER, 32'h22);
    wr(`POS_OFS_CTRL, 32'hC1);
    ev(3'b001, 3, 6'h12);
    // basic push-pull ignores steering; parity restarts at odd
    wr(`POS_OFS_CTRL, 32'h00);
    wr(`POS_OFS_STEER, 32'h3C);
    wr(`POS_OFS_CTRL, 32'hC2);
    ev(3'b100, 1, 6'h00);
    ev(3'b010, 3, 6'h01);
    ev(3'b001, 3, 6'h00);
    ev(3'b100, 1, 6'h00);
    ev(3'b010, 3, 6'h02);
    ev(3'b001, 3, 6'h00);
    ev(3'b100, 1, 6'h00);
    ev(3'b010, 3, 6'h01);
    ev(3'b001, 3, 6'h00);
    // six-step: even steer bits primary, odd bits complementary
    wr(`POS_OFS_CTRL, 32'h00);
    wr(`POS_OFS_STEER, 32'h0F);
    wr(`POS_OFS_CTRL, 32'hCC);
    ev(3'b001, 3, 6'h0A);
    ev(3'b010, 3, 6'h05);
    final_report();
  end

  // the sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge mclk_i);
    n_mismatch++;
    final_report();
  end
endmodule
